// File: shared/status_flag_regs.svh
// Register indices, field positions, reset values and timing counts
`ifndef STATUS_FLAG_REGS_SVH
`define STATUS_FLAG_REGS_SVH
`define IDX_DATA_A_LO   7'h08
`define IDX_DATA_A_HI   7'h0a
`define IDX_DATA_B_LO   7'h0e
`define IDX_DATA_B_HI   7'h17
`define IDX_PRIMARY     7'h0b
`define IDX_CTRL        7'h28
`define IDX_FIFO_LEVEL  7'h29
`define IDX_FIFO_DATA   7'h2a
`define IDX_AUX_HI      7'h2c
`define IDX_AUX_LO      7'h2d
`define IDX_KNOCK_LEVEL 7'h2e
`define IDX_KNOCK_MAX   7'h2f
`define IDX_KNOCK_GAP   7'h30
`define IDX_KNOCK_WIN   7'h31
`define IDX_IRQ_STATUS  7'h32
`define IDX_IRQ_MASK    7'h33
`define IDX_SECONDARY   7'h45
`define PRI_OVERRUN     3
`define PRI_LEVEL       2
`define PRI_NONEMPTY    1
`define PRI_NEW_SAMPLE  0
`define SEC_FUSE_ERR    7
`define SEC_NVM_RELOAD  6
`define SEC_RESERVED    5
`define SEC_KEEPALIVE   4
`define SEC_OVER        3
`define SEC_UNDER       2
`define SEC_DOUBLE      1
`define SEC_SINGLE      0
`define SEC_CLR_MASK    8'h5f
`define SEC_RESET       8'h00
`define CTRL_OLDEST     0
`define CTRL_TEMP_EN    1
`define CTRL_RESET      8'h01
`define LEVEL_RESET     5'h08
`define FIFO_DEPTH      5'h10
`define CLK_MHZ         125
`define KA_TIME_US      1000
`define KA_CYCLES       (`KA_TIME_US * `CLK_MHZ)
`define RESP_OKAY       2'b00
`define RESP_DECERR     2'b11
`endif

// File: shared/status_flag_pkg.sv
// Types shared by the status flag logic
package status_flag_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [4:0] count_t;
    typedef enum logic [1:0] {
        TAP_IDLE   = 2'b00,
        TAP_FIRST  = 2'b01,
        TAP_GAP    = 2'b11,
        TAP_SECOND = 2'b10
    } tap_state_e;
endpackage

// File: hdl/status_flag_logic.sv
// Status flag logic with an AXI4-Lite register slave
// Function
// (RULE1) On buffer overrun raise overflow and drop samples until a read frees space.
// (RULE2) Overflow flag exists only in oldest-saved buffer mode.
// (RULE3) Level flag asserts once buffer holds more than the configured count.
// (RULE4) Non-empty flag is one exactly while samples wait in the buffer.
// (RULE5) New-sample flag sets on fresh data, clears on a data register read.
// (RULE6) New-sample flag never sets while a register read is in progress.
// (RULE7) Fresh data during a read with flag clear sets it when read ends.
// (RULE8) Flag set at data read start clears, stays clear, resets after if new.
// (RULE9) Fuse-uncorrectable flag sets on unrepairable fuse corruption.
// (RULE10) NVM-reload flag sets on reload, clears on secondary register read.
// (RULE11) Keep-alive expiry sets flag; secondary read clears and restarts timer.
// (RULE12) Over-limit flag on value above threshold; temp channel if enabled.
// (RULE13) Under-limit flag on value below threshold; temp channel if enabled.
// (RULE14) Double-tap: two short knocks, second after min gap and within window.
// (RULE15) Single-tap: one knock above level shorter than maximum length.
// (RULE16) Secondary register at 0x45, resets to zero, reserved bit reads zero.
// (RULE17) Reads return values at read start; clear-on-read never loses a set.
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "status_flag_regs.svh"
module status_flag_logic #(
    parameter int unsigned KA_CYCLES = `KA_CYCLES
) (
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic [11:0]           s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [11:0]           s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    input  wire logic                  sample_valid,
    input  wire status_flag_pkg::byte_t sample_in,
    input  wire logic                  aux_valid,
    input  wire status_flag_pkg::byte_t temp_sample,
    input  wire status_flag_pkg::byte_t adc_sample,
    input  wire logic                  accel_valid,
    input  wire status_flag_pkg::byte_t accel_mag,
    input  wire logic                  fuse_uncorrectable,
    input  wire logic                  nvm_reload_done,
    output logic                       irq
);
    import status_flag_pkg::*;

    function automatic logic is_data(input logic [6:0] i);
        return (i >= `IDX_DATA_A_LO && i <= `IDX_DATA_A_HI) ||
               (i >= `IDX_DATA_B_LO && i <= `IDX_DATA_B_HI);
    endfunction

    logic [6:0]  ar_idx;
    logic        ar_fire;
    logic        r_fire;
    logic        data_rd;
    logic        sec_rd;
    logic        pop;
    logic [31:0] rd_word;
    logic        rd_ok;
    logic [6:0]  aw_idx;
    logic        aw_held;
    logic        w_held;
    byte_t       w_byte;
    logic        w_en;
    logic        w_lane0;
    byte_t       ctrl;
    count_t      level;
    byte_t       aux_hi;
    byte_t       aux_lo;
    byte_t       knock_level;
    byte_t       knock_max_length;
    byte_t       knock_gap_min;
    byte_t       knock_window;
    byte_t       irq_status;
    byte_t       irq_mask;
    byte_t       sample_hold;
    byte_t       fifo_mem [16];
    logic [3:0]  wr_ptr;
    logic [3:0]  rd_ptr;
    count_t      count;
    logic        full;
    logic        push;
    logic        overrun;
    logic        buffer_level_reached;
    logic        level_q, dr_q;
    logic        data_ready;
    logic        pending;
    byte_t       secondary_flags;
    logic [17:0] ka_cnt;
    logic        ka_expire;
    byte_t       aux_src;
    logic        aux_over_limit;
    logic        aux_under_limit;
    tap_state_e  tap_state;
    byte_t       tap_cnt;
    logic        knock_above;
    logic        single_ev;
    logic        double_ev;
    byte_t       next_sec;
    byte_t       irq_ev;

    // Reads: one at a time, snapshot taken at address acceptance
    assign s_axi_arready = !s_axi_rvalid;
    assign ar_fire = s_axi_arvalid && s_axi_arready;
    assign r_fire  = s_axi_rvalid && s_axi_rready;
    assign ar_idx  = s_axi_araddr[8:2];
    assign data_rd = ar_fire && s_axi_araddr[11:9] == 3'h0 && is_data(ar_idx);
    assign sec_rd  = ar_fire && s_axi_araddr[11:9] == 3'h0 && ar_idx == `IDX_SECONDARY;
    assign pop = ar_fire && s_axi_araddr[11:9] == 3'h0 && ar_idx == `IDX_FIFO_DATA
                 && count != 5'h00;

    always_comb begin
        rd_word = 32'h0000_0000;
        rd_ok   = (s_axi_araddr[11:9] == 3'h0);
        if (is_data(ar_idx)) begin
            rd_word[7:0] = sample_hold;
        end else begin
            unique case (ar_idx)
                `IDX_PRIMARY: rd_word[3:0] = {overrun, buffer_level_reached,
                                              count != 5'h00, data_ready};
                `IDX_CTRL:        rd_word[7:0] = ctrl;
                `IDX_FIFO_LEVEL:  rd_word[4:0] = level;
                `IDX_FIFO_DATA:   rd_word[7:0] = fifo_mem[rd_ptr];
                `IDX_AUX_HI:      rd_word[7:0] = aux_hi;
                `IDX_AUX_LO:      rd_word[7:0] = aux_lo;
                `IDX_KNOCK_LEVEL: rd_word[7:0] = knock_level;
                `IDX_KNOCK_MAX:   rd_word[7:0] = knock_max_length;
                `IDX_KNOCK_GAP:   rd_word[7:0] = knock_gap_min;
                `IDX_KNOCK_WIN:   rd_word[7:0] = knock_window;
                `IDX_IRQ_STATUS:  rd_word[7:0] = irq_status;
                `IDX_IRQ_MASK:    rd_word[7:0] = irq_mask;
                `IDX_SECONDARY:   rd_word[7:0] = secondary_flags; // RULE17
                default:          rd_ok = 1'b0;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `RESP_OKAY;
        end else if (ar_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_ok ? rd_word : 32'h0000_0000;
            s_axi_rresp  <= rd_ok ? `RESP_OKAY : `RESP_DECERR;
        end else if (r_fire) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Writes: address and data latched in either order
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign w_en = aw_held && w_held;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_idx  <= 7'h00;
            w_byte  <= 8'h00;
            w_lane0 <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_idx  <= s_axi_awaddr[11:9] == 3'h0 ? s_axi_awaddr[8:2] : 7'h7f;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held  <= 1'b1;
                w_byte  <= s_axi_wdata[7:0];
                w_lane0 <= s_axi_wstrb[0];
            end
            if (w_en) begin
                aw_held <= 1'b0;
                w_held  <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= aw_idx == 7'h7f ? `RESP_DECERR : `RESP_OKAY;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl             <= `CTRL_RESET;
            level            <= `LEVEL_RESET;
            aux_hi           <= 8'hff;
            aux_lo           <= 8'h00;
            knock_level      <= 8'h80;
            knock_max_length <= 8'h04;
            knock_gap_min    <= 8'h02;
            knock_window     <= 8'h10;
            irq_mask         <= 8'h00;
        end else if (w_en && w_lane0) begin
            unique case (aw_idx)
                `IDX_CTRL:        ctrl <= {6'h00, w_byte[1:0]};
                `IDX_FIFO_LEVEL:  level <= w_byte[4:0];
                `IDX_AUX_HI:      aux_hi <= w_byte;
                `IDX_AUX_LO:      aux_lo <= w_byte;
                `IDX_KNOCK_LEVEL: knock_level <= w_byte;
                `IDX_KNOCK_MAX:   knock_max_length <= w_byte;
                `IDX_KNOCK_GAP:   knock_gap_min <= w_byte;
                `IDX_KNOCK_WIN:   knock_window <= w_byte;
                `IDX_IRQ_MASK:    irq_mask <= w_byte;
                default:          ;
            endcase
        end
    end

    // Sample buffer
    assign full = (count == `FIFO_DEPTH);
    // Oldest-saved mode refuses a full buffer; otherwise oldest is overwritten
    assign push = sample_valid && (!full || pop || !ctrl[`CTRL_OLDEST]); // RULE1
    assign buffer_level_reached = (count > level); // RULE3

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_ptr <= 4'h0;
            rd_ptr <= 4'h0;
            count  <= 5'h00;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 4'h1;
            end
            if (pop || (push && full && !pop)) begin
                rd_ptr <= rd_ptr + 4'h1;
            end
            if (push && !pop && !full) begin
                count <= count + 5'h01; // RULE4
            end else if (pop && !push) begin
                count <= count - 5'h01; // RULE4
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (push) begin
            fifo_mem[wr_ptr] <= sample_in;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            overrun <= 1'b0;
        end else if (!ctrl[`CTRL_OLDEST]) begin
            overrun <= 1'b0; // RULE2
        end else if (sample_valid && full && !pop) begin
            overrun <= 1'b1; // RULE1
        end else if (pop) begin
            overrun <= 1'b0;
        end
    end

    // New-sample flag with deferral across register reads
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_ready  <= 1'b0;
            pending     <= 1'b0;
            sample_hold <= 8'h00;
        end else begin
            if (sample_valid) begin
                sample_hold <= sample_in;
            end
            if (ar_fire) begin
                if (data_rd) begin
                    data_ready <= 1'b0; // RULE8
                end
                pending <= sample_valid; // RULE6
            end else if (s_axi_rvalid) begin
                if (r_fire) begin
                    if (pending || sample_valid) begin
                        data_ready <= 1'b1; // RULE7
                    end
                    pending <= 1'b0;
                end else if (sample_valid) begin
                    pending <= 1'b1; // RULE6
                end
            end else if (sample_valid) begin
                data_ready <= 1'b1; // RULE5
            end
        end
    end

    // Keep-alive timer, halted at zero until the secondary register is read
    assign ka_expire = (ka_cnt == 18'h00001);
    always_ff @(posedge aclk) begin
        if (!aresetn || sec_rd) begin
            ka_cnt <= KA_CYCLES[17:0]; // RULE11
        end else if (ka_cnt != 18'h00000) begin
            ka_cnt <= ka_cnt - 18'h00001;
        end
    end

    assign aux_src = ctrl[`CTRL_TEMP_EN] ? temp_sample : adc_sample; // RULE12
    assign aux_over_limit  = aux_valid && aux_src > aux_hi;  // RULE12
    assign aux_under_limit = aux_valid && aux_src < aux_lo;  // RULE13

    // Knock detector, counts in accelerometer sample ticks
    assign knock_above = accel_mag > knock_level;
    assign single_ev = accel_valid && tap_state == TAP_FIRST && !knock_above; // RULE15
    assign double_ev = accel_valid && tap_state == TAP_SECOND && !knock_above; // RULE14

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tap_state <= TAP_IDLE;
            tap_cnt   <= 8'h00;
        end else if (accel_valid) begin
            tap_cnt <= tap_cnt + 8'h01;
            unique case (tap_state)
                TAP_IDLE: begin
                    tap_cnt <= 8'h01;
                    if (knock_above) begin
                        tap_state <= TAP_FIRST;
                    end
                end
                TAP_FIRST: begin
                    // Too long a knock drops back; it may rearm while held
                    if (knock_above && tap_cnt >= knock_max_length) begin
                        tap_state <= TAP_IDLE;
                    end else if (!knock_above) begin
                        tap_state <= TAP_GAP;
                        tap_cnt   <= 8'h01;
                    end
                end
                TAP_GAP: begin
                    if (knock_above) begin
                        tap_cnt   <= 8'h01;
                        tap_state <= (tap_cnt >= knock_gap_min && tap_cnt <= knock_window)
                                     ? TAP_SECOND : TAP_IDLE; // RULE14
                    end else if (tap_cnt > knock_window) begin
                        tap_state <= TAP_IDLE;
                    end
                end
                TAP_SECOND: begin
                    if (!knock_above || tap_cnt >= knock_max_length) begin
                        tap_state <= TAP_IDLE;
                    end
                end
            endcase
        end
    end

    // Secondary flags: clear-on-read first, then new events win
    always_comb begin
        next_sec = secondary_flags;
        if (sec_rd) begin
            next_sec = secondary_flags & ~`SEC_CLR_MASK; // RULE10
        end
        next_sec[`SEC_FUSE_ERR]   = next_sec[`SEC_FUSE_ERR] | fuse_uncorrectable; // RULE9
        next_sec[`SEC_NVM_RELOAD] = next_sec[`SEC_NVM_RELOAD] | nvm_reload_done;  // RULE10
        next_sec[`SEC_KEEPALIVE]  = next_sec[`SEC_KEEPALIVE] | ka_expire;         // RULE11
        next_sec[`SEC_OVER]       = next_sec[`SEC_OVER] | aux_over_limit;         // RULE12
        next_sec[`SEC_UNDER]      = next_sec[`SEC_UNDER] | aux_under_limit;       // RULE13
        next_sec[`SEC_DOUBLE]     = next_sec[`SEC_DOUBLE] | double_ev;            // RULE14
        next_sec[`SEC_SINGLE]     = next_sec[`SEC_SINGLE] | single_ev;            // RULE15
        next_sec[`SEC_RESERVED]   = 1'b0;                                         // RULE16
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            secondary_flags <= `SEC_RESET; // RULE16
        end else begin
            secondary_flags <= next_sec; // RULE17
        end
    end

    // Interrupt status, cleared by its own read; set wins
    assign irq_ev = {nvm_reload_done, aux_over_limit | aux_under_limit, ka_expire,
                     double_ev, single_ev, ctrl[`CTRL_OLDEST] & sample_valid & full & !pop,
                     buffer_level_reached & !level_q, data_ready & !dr_q};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status <= 8'h00;
            {level_q, dr_q} <= 2'b00;
        end else begin
            {level_q, dr_q} <= {buffer_level_reached, data_ready};
            if (ar_fire && s_axi_araddr[11:9] == 3'h0 && ar_idx == `IDX_IRQ_STATUS) begin
                irq_status <= irq_ev;
            end else begin
                irq_status <= irq_status | irq_ev;
            end
        end
    end
    assign irq = |(irq_status & irq_mask);

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_ovf_set: assert property (sample_valid && full && ctrl[0] && !pop
        |=> overrun && count == `FIFO_DEPTH && $stable(wr_ptr)) // RULE1
        else $error("overrun not raised or full buffer written");
    chk_ovf_mode: assert property (!ctrl[0] |=> !overrun) // RULE2
        else $error("overrun flag outside oldest mode");
    chk_level_rise: assert property (push && !pop && !full && count == level
        |=> buffer_level_reached) // RULE3
        else $error("level flag missing after sample above level");
    chk_empty_drop: assert property (pop && !push && count == 5'h01
        |=> count == 5'h00 && !$past(count == 5'h00)) // RULE4
        else $error("non-empty state wrong after last pop");
    chk_dr_clear: assert property (data_rd |=> !data_ready) // RULE8
        else $error("new-sample flag not cleared at data read start");
    chk_dr_hold: assert property (s_axi_rvalid && !r_fire |=> !$rose(data_ready)) // RULE6
        else $error("new-sample flag rose during a read");
    chk_dr_after: assert property (r_fire && pending |=> data_ready) // RULE7
        else $error("deferred new-sample flag lost");
    chk_sec_clear: assert property (sec_rd && !nvm_reload_done
        |=> !secondary_flags[6] && ka_cnt == KA_CYCLES[17:0]) // RULE10
        else $error("secondary read did not clear or restart timer");
    chk_ka_expire: assert property (ka_cnt == 18'h00001 |=> secondary_flags[4]) // RULE11
        else $error("keep-alive expiry not flagged");
    chk_sec_snap: assert property (sec_rd |=> s_axi_rdata[7:0] == $past(secondary_flags)
        && s_axi_rdata[31:8] == 24'h000000 && !s_axi_rdata[5]) // RULE17
        else $error("secondary read not a start-of-read snapshot");
    chk_over_flag: assert property (aux_valid && aux_src > aux_hi |=> secondary_flags[3]) // RULE12
        else $error("over-limit not flagged");
    chk_under_flag: assert property (aux_valid && aux_src < aux_lo |=> secondary_flags[2]) // RULE13
        else $error("under-limit not flagged");
    chk_tap_flags: assert property ((single_ev |=> secondary_flags[0]) and
        (double_ev |=> secondary_flags[1])) // RULE15
        else $error("knock event not flagged");
    chk_fuse_flag: assert property (fuse_uncorrectable |=> secondary_flags[7]) // RULE9
        else $error("fuse error not flagged");

    cov_overrun: cover property (sample_valid && full && ctrl[0]);
    cov_deferred: cover property (r_fire && pending);
    cov_double: cover property (double_ev);
    cov_sec_read: cover property (sec_rd && secondary_flags != 8'h00);
endmodule

// File: sim/host_axi_model.sv
// Host model: AXI4-Lite master making one register access at a time
`timescale 1ns/100ps
module host_axi_model (
    input  wire logic        aclk,
    output logic [11:0]      awaddr,
    output logic             awvalid,
    input  wire logic        awready,
    output logic [31:0]      wdata,
    output logic [3:0]       wstrb,
    output logic             wvalid,
    input  wire logic        wready,
    input  wire logic        bvalid,
    output logic             bready,
    output logic [11:0]      araddr,
    output logic             arvalid,
    input  wire logic        arready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp,
    input  wire logic        rvalid,
    output logic             rready
);
    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata, wstrb} = '0;
    end
    task automatic write_reg(input logic [11:0] a, input logic [7:0] d);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= {24'h0, d};
        wstrb   <= 4'h1;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            // Released lines flip so a stale value cannot pass
            if (awvalid && awready) begin
                awvalid <= 1'b0;
                awaddr  <= ~a;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
                wdata  <= ~wdata;
            end
        end while (!bvalid);
        bready <= 1'b0;
    endtask
    task automatic read_reg(input logic [11:0] a, output logic [7:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) begin
                arvalid <= 1'b0;
                araddr  <= ~a;
            end
        end while (!rvalid);
        d = rdata[7:0];
        r = rresp;
        rready <= 1'b0;
    endtask
endmodule

// File: sim/status_flag_logic_tb_top.sv
// Self-checking bench for the status flag logic
`timescale 1ns/100ps
module status_flag_logic_tb_top;
    logic        aclk, aresetn, sample_valid, fuse_uncorrectable, nvm_reload_done, irq;
    logic        awvalid, awready, wvalid, wready, bvalid, bready, aux_valid;
    logic        arvalid, arready, rvalid, rready;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  rresp, r;
    logic [7:0]  v, sample_in, temp_sample, adc_sample;
    int          mismatches = 0, n_compared = 0;
    status_flag_logic #(.KA_CYCLES(20)) DUT (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sample_valid(sample_valid),
        .sample_in(sample_in), .aux_valid(aux_valid), .temp_sample(temp_sample),
        .adc_sample(adc_sample), .accel_valid(1'b0), .accel_mag(8'h00),
        .fuse_uncorrectable(fuse_uncorrectable), .nvm_reload_done(nvm_reload_done),
        .irq(irq));
    host_axi_model host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h, want %h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("mismatches %0d, compared %0d", mismatches, n_compared);
        if (mismatches == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic rst();
        aresetn <= 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
    endtask
    task automatic push(input int n);
        @(posedge aclk);
        sample_valid <= 1'b1;
        repeat (n) @(posedge aclk);
        sample_valid <= 1'b0;
    endtask
    // Timer bit masked; the first read restarts keep-alive 2 cycles after reset, before it can expire
    task automatic t_sec_reset();
        host.read_reg(12'h114, v, r);
        chk(v & 8'hef, 8'h00);
        host.read_reg(12'h1fc, v, r);
        chk({6'h0, r}, 8'h03);
    endtask
    task automatic t_events();
        @(posedge aclk);
        {fuse_uncorrectable, nvm_reload_done} <= 2'b11;
        @(posedge aclk);
        {fuse_uncorrectable, nvm_reload_done} <= 2'b00;
        host.read_reg(12'h114, v, r);
        chk(v & 8'hef, 8'hc0);
        host.read_reg(12'h114, v, r);
        chk(v & 8'hef, 8'h80);
    endtask
    task automatic t_keepalive();
        host.read_reg(12'h114, v, r);
        repeat (5) @(posedge aclk);
        host.read_reg(12'h114, v, r);
        chk(v & 8'h10, 8'h00);
        repeat (30) @(posedge aclk);
        host.read_reg(12'h114, v, r);
        chk(v & 8'h10, 8'h10);
    endtask
    task automatic t_new_sample();
        push(1);
        host.read_reg(12'h02c, v, r);
        chk(v & 8'h01, 8'h01);
        host.read_reg(12'h020, v, r);
        chk(v, 8'h5a);
        host.read_reg(12'h02c, v, r);
        chk(v & 8'h01, 8'h00);
    endtask
    task automatic t_buffer();
        host.write_reg(12'h0cc, 8'h00);
        push(8);
        host.read_reg(12'h02c, v, r);
        chk(v & 8'h0e, 8'h02);
        push(1);
        host.read_reg(12'h02c, v, r);
        chk(v & 8'h0e, 8'h06);
        chk({7'h0, irq}, 8'h00);
        push(8);
        host.read_reg(12'h02c, v, r);
        chk(v & 8'h0e, 8'h0e);
        host.read_reg(12'h0a4, v, r);
        chk(v & 8'h1f, 8'h08);
        host.read_reg(12'h0a8, v, r);
        chk(v, 8'h5a);
        host.read_reg(12'h02c, v, r);
        chk(v & 8'h0e, 8'h06);
        host.write_reg(12'h0cc, 8'h02);
        chk({7'h0, irq}, 8'h01);
        host.read_reg(12'h0c8, v, r);
        chk(v & 8'h02, 8'h02);
        chk({7'h0, irq}, 8'h00);
    endtask
    // Same samples twice: source select decides which limit trips
    task automatic t_aux();
        host.write_reg(12'h0b0, 8'h40);
        host.write_reg(12'h0b4, 8'h20);
        {temp_sample, adc_sample} <= 16'h1050;
        @(posedge aclk);
        aux_valid <= 1'b1;
        @(posedge aclk);
        aux_valid <= 1'b0;
        host.read_reg(12'h114, v, r);
        chk(v & 8'h0c, 8'h08);
        host.write_reg(12'h0a0, 8'h03);
        @(posedge aclk);
        aux_valid <= 1'b1;
        @(posedge aclk);
        aux_valid <= 1'b0;
        host.read_reg(12'h114, v, r);
        chk(v & 8'h0c, 8'h04);
    endtask
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    initial begin
        #200000;
        mismatches++;
        results();
    end
    initial begin
        {aresetn, sample_valid, fuse_uncorrectable, nvm_reload_done, aux_valid} = 5'h00;
        {sample_in, temp_sample, adc_sample} = 24'h5a0000;
        rst();
        t_sec_reset();
        t_events();
        rst();
        t_sec_reset();
        t_keepalive();
        t_new_sample();
        rst();
        t_buffer();
        t_aux();
        results();
    end
endmodule
